// ---- core/swr_rom_layer.sv ----
// Single-wire ROM command layer with speed control and resume flag.
// Operation
// - Read command sends family, serial, CRC.
// - Match proceeds only on full identity equality.
// - Mismatched device stays passive until reset.
// - Search: bit, complement, then master direction.
// - Conditional search only when wiper is zero.
// - Skip goes straight to function layer.
// - Overdrive skip selects and enters overdrive.
// - Reset of 480 us drops overdrive.
// - Short reset keeps overdrive mode.
// - Overdrive match selects at overdrive speed.
// - Prior overdrive survives another device's match.
// - Resume acts like skip only if flagged.
// - Flag set only by successful selecting commands.
// - Flag cleared when another device is selected.
// - Presence waits a set time after reset.
// - Presence pulse has a set low time.
// - Regular speed unless overdrive; overdrive times everything.
// - Master falling edge starts the slot timer.
// - Write slot sampled at fixed timer delay.
// - Read zero holds line low; one releases.
// - Commands are eight bits after reset.
// - Bus idles high; long low is reset.
`default_nettype none
module swr_rom_layer #(
    parameter logic [63:0] ROM_ID = swr_pkg::ROM_ID_DEFAULT,
    parameter int LONG_RESET_CYCLES = swr_pkg::LONG_RST_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic line_in,
    input wire logic [7:0] wiper_pos,
    output logic line_out,
    output logic line_oe_n,
    output logic overdrive,
    output logic resume_flag,
    output logic func_active
);
    import swr_pkg::*;

    swr_line_if lk(); // Link to the line timer.
    swr_state_type state_reg; // Command layer state.
    logic [5:0] idx_reg; // Bit counter within the current field.
    logic [7:0] shift_reg; // Command byte assembly, LSB first.
    logic miss_reg; // A match bit has differed.
    logic od_match_reg; // Current match runs at overdrive.
    logic od_prev_reg; // Speed before an overdrive match began.
    logic [7:0] cmd_byte;
    logic rom_bit;
    logic last;
    logic cmd_done;
    logic match_end;
    logic match_ok;
    logic srch_dir;
    logic srch_fail;
    logic srch_ok;

    // The timer sees the synchronous line input.
    assign lk.line_in = line_in;

    swr_slot_timer #(
        .LONG_CYC(LONG_RESET_CYCLES)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .lk(lk)
    );

    // Decode helpers for the current bit.
    assign cmd_byte = {lk.rx_bit, shift_reg[7:1]};
    assign rom_bit = ROM_ID[idx_reg];
    assign last = idx_reg == 6'h3f;
    assign cmd_done = state_reg == S_CMD && lk.bit_done && idx_reg == 6'h07;
    assign match_end = state_reg == S_MATCH && lk.bit_done && last;
    assign match_ok = match_end && !miss_reg && lk.rx_bit == rom_bit;
    assign srch_dir = state_reg == S_SRCH_D && lk.bit_done;
    assign srch_fail = srch_dir && lk.rx_bit != rom_bit;
    assign srch_ok = srch_dir && last && !srch_fail;
    assign lk.od = overdrive;

    // What the device sends in the next slot.
    always_comb begin
        lk.tx_en = 1'b0;
        lk.tx_bit = 1'b1;
        case (state_reg)
            S_READ: begin
                lk.tx_en = 1'b1;
                lk.tx_bit = rom_bit;
            end
            S_SRCH_B: begin
                lk.tx_en = 1'b1;
                lk.tx_bit = rom_bit;
            end
            S_SRCH_C: begin
                lk.tx_en = 1'b1;
                lk.tx_bit = ~rom_bit;
            end
            default: begin
                lk.tx_en = 1'b0;
                lk.tx_bit = 1'b1;
            end
        endcase
    end

    // Command sequencing; every reset restarts at the command byte.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= S_CMD;
            idx_reg <= '0;
            shift_reg <= '0;
            miss_reg <= 1'b0;
            od_match_reg <= 1'b0;
        end else if (lk.reset_seen) begin
            state_reg <= S_CMD;
            idx_reg <= '0;
            miss_reg <= 1'b0;
            od_match_reg <= 1'b0;
        end else if (lk.bit_done) begin
            case (state_reg)
                S_CMD: begin
                    // Assemble the command byte, then dispatch.
                    shift_reg <= cmd_byte;
                    idx_reg <= idx_reg + 1'b1;
                    if (idx_reg == 6'h07) begin
                        idx_reg <= '0;
                        case (cmd_byte)
                            CMD_READ: state_reg <= S_READ;
                            CMD_MATCH: state_reg <= S_MATCH;
                            CMD_SEARCH: state_reg <= S_SRCH_B;
                            CMD_CSEARCH: begin
                                // Only a wiper at its power-on value joins.
                                if (wiper_pos == WIPER_DEFAULT) begin
                                    state_reg <= S_SRCH_B;
                                end else begin
                                    state_reg <= S_PASSIVE;
                                end
                            end
                            CMD_SKIP: state_reg <= S_FUNC;
                            CMD_ODSKIP: state_reg <= S_FUNC;
                            CMD_ODMATCH: begin
                                state_reg <= S_MATCH;
                                od_match_reg <= 1'b1;
                            end
                            CMD_RESUME: begin
                                if (resume_flag) begin
                                    state_reg <= S_FUNC;
                                end else begin
                                    state_reg <= S_PASSIVE;
                                end
                            end
                            default: state_reg <= S_PASSIVE;
                        endcase
                    end
                end
                S_READ: begin
                    // Identity goes out bit by bit, then the function layer.
                    idx_reg <= idx_reg + 1'b1;
                    if (last) begin
                        state_reg <= S_FUNC;
                    end
                end
                S_MATCH: begin
                    // Compare every received bit with our identity.
                    idx_reg <= idx_reg + 1'b1;
                    if (lk.rx_bit != rom_bit) begin
                        miss_reg <= 1'b1;
                    end
                    if (match_ok) begin
                        state_reg <= S_FUNC;
                    end else if (last) begin
                        state_reg <= S_PASSIVE;
                    end
                end
                S_SRCH_B: state_reg <= S_SRCH_C;
                S_SRCH_C: state_reg <= S_SRCH_D;
                S_SRCH_D: begin
                    // Follow the master's direction or drop out.
                    idx_reg <= idx_reg + 1'b1;
                    if (srch_fail) begin
                        state_reg <= S_PASSIVE;
                    end else if (srch_ok) begin
                        state_reg <= S_FUNC;
                    end else begin
                        state_reg <= S_SRCH_B;
                    end
                end
                default: begin
                    // Function layer and passive both wait for a reset.
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Speed: a long reset leaves overdrive; a failed overdrive match restores the speed held before it.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            overdrive <= 1'b0;
            od_prev_reg <= 1'b0;
        end else if (lk.reset_seen) begin
            if (lk.reset_long) begin
                overdrive <= 1'b0;
            end
        end else if (cmd_done && (cmd_byte == CMD_ODSKIP || cmd_byte == CMD_ODMATCH)) begin
            od_prev_reg <= overdrive;
            overdrive <= 1'b1;
        end else if (match_end && od_match_reg && !match_ok) begin
            overdrive <= od_prev_reg;
        end
    end

    // Resume flag: set by our selection, cleared when another is selected.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resume_flag <= 1'b0;
        end else if (match_ok || srch_ok) begin
            resume_flag <= 1'b1;
        end else if ((match_end && !match_ok) || srch_fail) begin
            resume_flag <= 1'b0;
        end
    end

    // Registered pin and status outputs; the pin only ever pulls low.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_out <= 1'b0;
            line_oe_n <= 1'b1;
            func_active <= 1'b0;
        end else begin
            line_out <= 1'b0;
            line_oe_n <= ~lk.drive_low;
            func_active <= state_reg == S_FUNC;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_cmd(logic [7:0] code);
        cmd_done && cmd_byte == code;
    endsequence

    a_read_bits: assert property (state_reg == S_READ |-> lk.tx_en && lk.tx_bit == ROM_ID[idx_reg])
        else $error("identity bit sent wrongly");
    a_match_select: assert property (match_ok |=> state_reg == S_FUNC && resume_flag)
        else $error("full match did not select");
    a_match_passive: assert property (match_end && !match_ok |=> state_reg == S_PASSIVE [*1])
        else $error("mismatch did not go passive");
    a_passive_quiet: assert property (state_reg == S_PASSIVE && !lk.reset_seen |=> state_reg == S_PASSIVE)
        else $error("passive state left without reset");
    a_search_step: assert property (state_reg == S_SRCH_B && lk.bit_done && !lk.reset_seen
        |=> state_reg == S_SRCH_C && lk.tx_bit == !ROM_ID[idx_reg])
        else $error("search complement missing");
    a_cond_gate: assert property (s_cmd(CMD_CSEARCH) ##0 wiper_pos != WIPER_DEFAULT
        |=> state_reg == S_PASSIVE)
        else $error("conditional search joined wrongly");
    a_skip_func: assert property (s_cmd(CMD_SKIP) |=> state_reg == S_FUNC ##1 func_active)
        else $error("skip did not reach function layer");
    a_odskip: assert property (s_cmd(CMD_ODSKIP) |=> overdrive && state_reg == S_FUNC)
        else $error("overdrive skip failed");
    a_long_exit: assert property (lk.reset_seen && lk.reset_long |=> !overdrive)
        else $error("long reset kept overdrive");
    a_short_keep: assert property (lk.reset_seen && !lk.reset_long && overdrive |=> overdrive)
        else $error("short reset dropped overdrive");
    a_odmatch_keep: assert property (s_cmd(CMD_ODMATCH) ##0 overdrive |=> overdrive throughout
        (state_reg == S_MATCH [*2]))
        else $error("prior overdrive lost");
    a_resume_gate: assert property (s_cmd(CMD_RESUME) ##0 !resume_flag |=> state_reg == S_PASSIVE)
        else $error("resume answered without flag");
    a_flag_clear: assert property (srch_fail |=> !resume_flag)
        else $error("resume flag kept after dropout");
endmodule // swr_rom_layer
`default_nettype wire

// ---- include/swr_pkg.sv ----
// Shared constants and state types for the single-wire ROM layer.
`default_nettype none
package swr_pkg;
    // System clock period in nanoseconds (10 MHz).
    localparam int CLK_NS = 100;
    // Width of the line timers.
    localparam int CW = 16;
    // Line low time that counts as a reset, regular and overdrive, in microseconds.
    localparam int RST_US = 120;
    localparam int OD_RST_US = 16;
    // Reset length that drops overdrive, in microseconds.
    localparam int LONG_RST_US = 480;
    // Wait after the reset edge before presence, in microseconds.
    localparam int PWAIT_US = 30;
    localparam int OD_PWAIT_US = 3;
    // Presence low time, in microseconds.
    localparam int PLOW_US = 120;
    localparam int OD_PLOW_US = 12;
    // Sample point and read-zero hold after a slot edge, in microseconds.
    localparam int SMP_US = 30;
    localparam int OD_SMP_US = 3;
    localparam int HOLD_US = 30;
    localparam int OD_HOLD_US = 3;
    // Cycle counts, least times rounded up.
    localparam logic [CW-1:0] RST_CYC = CW'((RST_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] OD_RST_CYC = CW'((OD_RST_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam int LONG_RST_CYC = (LONG_RST_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam logic [CW-1:0] PWAIT_CYC = CW'((PWAIT_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] OD_PWAIT_CYC = CW'((OD_PWAIT_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] PLOW_CYC = CW'((PLOW_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] OD_PLOW_CYC = CW'((OD_PLOW_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] SMP_CYC = CW'((SMP_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] OD_SMP_CYC = CW'((OD_SMP_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] HOLD_CYC = CW'((HOLD_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] OD_HOLD_CYC = CW'((OD_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS);
    // Command codes.
    localparam logic [7:0] CMD_READ = 8'h33;
    localparam logic [7:0] CMD_MATCH = 8'h55;
    localparam logic [7:0] CMD_SEARCH = 8'hf0;
    localparam logic [7:0] CMD_CSEARCH = 8'hec;
    localparam logic [7:0] CMD_SKIP = 8'hcc;
    localparam logic [7:0] CMD_ODSKIP = 8'h3c;
    localparam logic [7:0] CMD_ODMATCH = 8'h69;
    localparam logic [7:0] CMD_RESUME = 8'ha5;
    // Wiper position after power-on.
    localparam logic [7:0] WIPER_DEFAULT = 8'h00;
    // Identity value; arbitrary, for simulation only.
    localparam logic [63:0] ROM_ID_DEFAULT = 64'h5a3c_9e17_42b6_0d2c;
    // Line timer states.
    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_SLOT = 2'b01,
        T_PWAIT = 2'b11,
        T_PRES = 2'b10
    } swr_tstate_type;
    // Command layer states.
    typedef enum logic [2:0] {
        S_CMD = 3'b000,
        S_MATCH = 3'b001,
        S_SRCH_B = 3'b011,
        S_SRCH_C = 3'b010,
        S_SRCH_D = 3'b110,
        S_READ = 3'b111,
        S_FUNC = 3'b101,
        S_PASSIVE = 3'b100
    } swr_state_type;
endpackage
`default_nettype wire

// ---- include/swr_line_if.sv ----
// Link between the command layer and the line timer.
`default_nettype none
interface swr_line_if;
    logic line_in;    // Sampled line level.
    logic od;         // Overdrive timing selected.
    logic tx_en;      // Device sends in the next slot.
    logic tx_bit;     // Bit to send.
    logic bit_done;   // One-cycle pulse at the sample point.
    logic rx_bit;     // Line level at the sample point.
    logic reset_seen; // One-cycle pulse at the end of a reset.
    logic reset_long; // Last reset was a long one.
    logic drive_low;  // Device pulls the line low.
    modport timer (input line_in, od, tx_en, tx_bit,
                   output bit_done, rx_bit, reset_seen, reset_long, drive_low);
    modport cmd (input bit_done, rx_bit, reset_seen, reset_long, drive_low,
                 output od, tx_en, tx_bit);
endinterface
`default_nettype wire

// ---- core/swr_slot_timer.sv ----
// Line timer: slot timing, reset detection and presence pulse.
`default_nettype none
module swr_slot_timer #(
    parameter int LONG_CYC = swr_pkg::LONG_RST_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    swr_line_if.timer lk
);
    import swr_pkg::*;

    logic line_prev_reg; // Line level one cycle back.
    logic od_low_reg; // Speed in force when the line last fell.
    logic [CW-1:0] low_reg; // Cycles the master has held the line low.
    logic [CW-1:0] cnt_reg; // Timer for slots and presence.
    swr_tstate_type st_reg; // Timer state.
    logic fall;
    logic rise;
    logic reset_hit;
    logic [CW-1:0] rst_cyc;
    logic [CW-1:0] smp_cyc;
    logic [CW-1:0] hold_cyc;
    logic [CW-1:0] pwait_cyc;
    logic [CW-1:0] plow_cyc;

    // Edges of the line and the speed-dependent timings.
    assign fall = line_prev_reg & ~lk.line_in;
    assign rise = ~line_prev_reg & lk.line_in;
    // A low is judged at the speed in force when it began, so a regular-speed write-zero
    // that ends after a switch to overdrive is not mistaken for a reset.
    assign rst_cyc = od_low_reg ? OD_RST_CYC : RST_CYC;
    assign smp_cyc = lk.od ? OD_SMP_CYC : SMP_CYC;
    assign hold_cyc = lk.od ? OD_HOLD_CYC : HOLD_CYC;
    assign pwait_cyc = lk.od ? OD_PWAIT_CYC : PWAIT_CYC;
    assign plow_cyc = lk.od ? OD_PLOW_CYC : PLOW_CYC;
    // A reset is a long low ended by a rising edge outside our own presence.
    assign reset_hit = rise && st_reg != T_PRES && low_reg >= rst_cyc;

    // Line history for edge detection, and the speed at the last falling edge.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_prev_reg <= 1'b1;
            od_low_reg <= 1'b0;
        end else begin
            line_prev_reg <= lk.line_in;
            if (fall) begin
                // Remember which reset threshold applies to this low.
                od_low_reg <= lk.od;
            end
        end
    end

    // Low-time counter; our presence pulse never counts as a master reset.
    // A read-zero we are sending still counts, so a reset that starts inside it keeps its full length.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_reg <= '0;
        end else if (lk.line_in || st_reg == T_PRES) begin
            low_reg <= '0;
        end else if (low_reg != '1) begin
            low_reg <= low_reg + 1'b1;
        end
    end

    // Slot, reset and presence sequencing.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= T_IDLE;
            cnt_reg <= '0;
            lk.drive_low <= 1'b0;
            lk.bit_done <= 1'b0;
            lk.rx_bit <= 1'b1;
            lk.reset_seen <= 1'b0;
            lk.reset_long <= 1'b0;
        end else begin
            lk.bit_done <= 1'b0;
            lk.reset_seen <= 1'b0;
            if (reset_hit) begin
                // Reset ends: wait, then answer with presence.
                lk.reset_seen <= 1'b1;
                lk.reset_long <= low_reg >= CW'(LONG_CYC);
                st_reg <= T_PWAIT;
                cnt_reg <= '0;
                lk.drive_low <= 1'b0;
            end else begin
                case (st_reg)
                    T_IDLE: begin
                        // The master's falling edge starts the slot timer.
                        if (fall) begin
                            st_reg <= T_SLOT;
                            cnt_reg <= 16'h0001;
                            lk.drive_low <= lk.tx_en & ~lk.tx_bit;
                        end
                    end
                    T_SLOT: begin
                        // Sample, release a zero, then wait for the line to rise.
                        if (cnt_reg != '1) begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                        if (cnt_reg == smp_cyc) begin
                            lk.rx_bit <= lk.line_in;
                            lk.bit_done <= 1'b1;
                        end
                        if (cnt_reg == hold_cyc) begin
                            lk.drive_low <= 1'b0;
                        end
                        if (cnt_reg > smp_cyc && cnt_reg > hold_cyc && lk.line_in) begin
                            st_reg <= T_IDLE;
                        end
                    end
                    T_PWAIT: begin
                        // Quiet wait after the reset edge.
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg + 1'b1 >= pwait_cyc) begin
                            st_reg <= T_PRES;
                            cnt_reg <= '0;
                            lk.drive_low <= 1'b1;
                        end
                    end
                    default: begin
                        // Presence pulse.
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg + 1'b1 >= plow_cyc) begin
                            st_reg <= T_IDLE;
                            lk.drive_low <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_presence_low: assert property (st_reg == T_PRES |-> lk.drive_low)
        else $error("presence not driven low");
    a_pwait_quiet: assert property (st_reg == T_PWAIT |-> !lk.drive_low)
        else $error("line driven during presence wait");
    a_sample_point: assert property ($rose(lk.bit_done) |-> $past(cnt_reg) == $past(smp_cyc))
        else $error("sample taken at wrong time");
    a_reset_presence: assert property (lk.reset_seen |-> !lk.drive_low [*2] ##0 st_reg == T_PWAIT)
        else $error("presence did not follow reset");
endmodule // swr_slot_timer
`default_nettype wire

// ---- bench/swr_master.sv ----
// Bus master model driving the single-wire line.
`default_nettype none
module swr_master (
    input wire logic clk,
    input wire logic line_oe_n,
    output logic line_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv_low = 1'b0; // Master pull-down; the pull-up idles the line high.
    bit od_spd = 1'b0; // Master uses overdrive timing.
    int pw; // Cycles from release to presence.
    int pl; // Presence low cycles.
    // Wired-AND of both pull-downs.
    assign line_in = line_oe_n & ~drv_low;
    // Pulls the line low for n cycles.
    task automatic low(input int n);
        drv_low <= 1'b1;
        repeat (n) @(posedge clk);
        drv_low <= 1'b0;
    endtask
    // Reset pulse, then timing of the presence answer.
    task automatic reset(input int n);
        low(n);
        pw = 0;
        pl = 0;
        do begin
            @(posedge clk);
            pw++;
        end while (line_in !== 1'b0 && pw < 3000);
        while (line_in === 1'b0 && pl < 3000) begin
            @(posedge clk);
            pl++;
        end
        repeat (od_spd ? 60 : 600) @(posedge clk);
    endtask
    // Write slot: short low for a one, long low for a zero.
    task automatic wbit(input logic b);
        int n;
        n = b ? (od_spd ? 5 : 50) : (od_spd ? 60 : 340);
        low(n);
        repeat ((od_spd ? 80 : 400) - n) @(posedge clk);
    endtask
    // Read slot: brief low, then sample before the device lets go.
    task automatic rbit(output logic b);
        low(od_spd ? 2 : 10);
        repeat (od_spd ? 13 : 140) @(posedge clk);
        b = line_in;
        repeat (od_spd ? 65 : 250) @(posedge clk);
    endtask
    // Sends a field least significant bit first.
    task automatic wfield(input logic [63:0] v, input int nb);
        for (int i = 0; i < nb; i++) wbit(v[i]);
    endtask
endmodule // swr_master
`default_nettype wire

// ---- bench/single_wire_rom_and_signaling_bench.sv ----
// Self-checking bench for the single-wire ROM layer.
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module single_wire_rom_and_signaling_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import swr_pkg::*;
    logic clk = 1'b0; // System clock.
    logic sys_rst = 1'b1; // Held at start.
    logic [7:0] wiper_pos = 8'h00; // Wiper level seen by the design.
    logic line_in, line_oe_n, od, rf, fa, b0, b1, lo;
    logic [63:0] id; // Identity as read back.
    logic [7:0] c; // Random unknown command.
    int seed = 32'hc6bf;
    int err_total = 0;
    int cmp_count = 0;
    logic exp_od = 1'b0; // Model of speed and flag.
    logic exp_rf = 1'b0;
    always #50 clk = ~clk;
    swr_rom_layer i_dut (.clk(clk), .sys_rst(sys_rst), .line_in(line_in), .wiper_pos(wiper_pos), .line_out(lo),
        .line_oe_n(line_oe_n), .overdrive(od), .resume_flag(rf), .func_active(fa));
    swr_master i_mst (.clk(clk), .line_oe_n(line_oe_n), .line_in(line_in));
    // Prints counts and verdict, then stops.
    task automatic test_done;
        $display("Errors %0d, compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bus reset and presence window at the current speed.
    task automatic rst_chk(input int n);
        i_mst.reset(n);
        `CHK(i_mst.pw inside {[(exp_od ? 20 : 150) : (exp_od ? 64 : 604)]}, 1'b1)
        `CHK(i_mst.pl inside {[(exp_od ? 80 : 600) : (exp_od ? 240 : 2400)]}, 1'b1)
    endtask
    // Compares selection, speed and flag with the model.
    task automatic settle(input logic f);
        repeat (4) @(posedge clk);
        `CHK({fa, od, rf, lo}, {f, exp_od, exp_rf, 1'b0})
    endtask
    // Hang guard.
    initial begin
        #12_000_000;
        err_total++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rst_chk(4800);
        i_mst.wfield(CMD_SKIP, 8);
        settle(1'b1);
        rst_chk(4800);
        i_mst.wfield(CMD_ODSKIP, 8);
        exp_od = 1'b1;
        settle(1'b1);
        i_mst.od_spd = 1'b1;
        rst_chk(500);
        i_mst.wfield(CMD_READ, 8);
        for (int i = 0; i < 64; i++) i_mst.rbit(id[i]);
        `CHK(id, ROM_ID_DEFAULT)
        rst_chk(500);
        i_mst.wfield(CMD_MATCH, 8);
        i_mst.wfield(ROM_ID_DEFAULT, 64);
        exp_rf = 1'b1;
        settle(1'b1);
        rst_chk(500);
        i_mst.wfield(CMD_RESUME, 8);
        settle(1'b1);
        rst_chk(500);
        i_mst.wfield(CMD_CSEARCH, 8);
        for (int i = 0; i < 64; i++) begin
            i_mst.rbit(b0);
            i_mst.rbit(b1);
            `CHK({b0, b1}, {ROM_ID_DEFAULT[i], ~ROM_ID_DEFAULT[i]})
            i_mst.wbit(ROM_ID_DEFAULT[i]);
        end
        settle(1'b1);
        rst_chk(500);
        i_mst.wfield(CMD_ODMATCH, 8);
        i_mst.wfield(ROM_ID_DEFAULT ^ (64'h1 << 6'($random(seed))), 64);
        exp_rf = 1'b0;
        i_mst.rbit(b0);
        `CHK(b0, 1'b1)
        settle(1'b0);
        rst_chk(500);
        i_mst.wfield(CMD_RESUME, 8);
        settle(1'b0);
        i_mst.od_spd = 1'b0;
        exp_od = 1'b0;
        rst_chk(4800);
        do c = 8'($random(seed));
        while (c inside {CMD_READ, CMD_MATCH, CMD_SEARCH, CMD_CSEARCH, CMD_SKIP, CMD_ODSKIP, CMD_ODMATCH, CMD_RESUME});
        i_mst.wfield(c, 8);
        i_mst.rbit(b0);
        `CHK(b0, 1'b1)
        settle(1'b0);
        rst_chk(4800);
        i_mst.wfield(CMD_ODMATCH, 8);
        i_mst.od_spd = 1'b1;
        i_mst.wfield(ROM_ID_DEFAULT, 64);
        exp_od = 1'b1;
        exp_rf = 1'b1;
        settle(1'b1);
        rst_chk(500);
        wiper_pos <= 8'($random(seed)) | 8'h01;
        i_mst.wfield(CMD_CSEARCH, 8);
        i_mst.rbit(b0);
        i_mst.rbit(b1);
        `CHK({b0, b1}, 2'b11)
        settle(1'b0);
        test_done();
    end
endmodule // single_wire_rom_and_signaling_bench
`default_nettype wire
